// ---- cs_params.svh ----
// Constants for the core system register and data-space decode block.
`ifndef CS_PARAMS_SVH
`define CS_PARAMS_SVH

// ----------------------------------------------------------------------
// Data space map
// ----------------------------------------------------------------------
`define CS_IO_SIZE        16'h0040
`define CS_BITIO_LAST     16'h001F
`define CS_SRAM_BASE      16'h0040
`define CS_SRAM_LAST      16'h005F
`define CS_SRAM_DEPTH     32
`define CS_DIRECT_BASE    16'h0040
`define CS_LOCK_ADDR      16'h3F00
`define CS_FLASH_BASE     16'h4000
`define CS_FLASH_LAST     16'h43FF
`define CS_PC_W           9

// ----------------------------------------------------------------------
// I/O offsets held in this block
// ----------------------------------------------------------------------
`define CS_OFS_KEY        6'h3C
`define CS_OFS_SPL        6'h3D
`define CS_OFS_SPH        6'h3E
`define CS_OFS_CORE_STATUS_FLAGS       6'h3F
`define CS_OFS_CLKSEL     6'h37
`define CS_OFS_CLKPRE     6'h36
`define CS_OFS_WDT        6'h31

// ----------------------------------------------------------------------
// Reset values, key and window
// ----------------------------------------------------------------------
`define CS_KEY_RST        8'h00
`define CS_CORE_STATUS_FLAGS_RST       8'h00
`define CS_PROT_RST       8'h00
`define CS_SP_RST         16'h005F
`define CS_UNLOCK_KEY     8'hD8
`define CS_WINDOW_INSNS   3'h4

// ----------------------------------------------------------------------
// Status bit positions
// ----------------------------------------------------------------------
`define CS_CORE_STATUS_FLAGS_I         7
`define CS_CORE_STATUS_FLAGS_T         6
`define CS_CORE_STATUS_FLAGS_H         5
`define CS_CORE_STATUS_FLAGS_S         4
`define CS_CORE_STATUS_FLAGS_V         3
`define CS_CORE_STATUS_FLAGS_N         2
`define CS_CORE_STATUS_FLAGS_Z         1
`define CS_CORE_STATUS_FLAGS_C         0

`endif

// ---- cs_periph_model.sv ----
// Peripheral registers, program flash and lock byte behind the block.
`timescale 1ns/1ps
`default_nettype none

module cs_periph_model #(
  parameter logic [7:0] LOCK_VAL = 8'hFC
) (
  input  wire logic            clk_in,
  input  wire cs_pkg::cs_iob_s iob_in,
  input  wire logic [8:0]      waddr_in,
  output logic [7:0]           rdata_out,
  output logic [15:0]          word_out,
  output logic [7:0]           lock_out
);
  logic [7:0] regs_r [0:63];

  initial for (int i = 0; i < 64; i++) regs_r[i] = 8'h00;

  // Only masked bits change, so write-one-to-clear neighbours survive.
  always @(posedge clk_in)
    if (iob_in.we)
      regs_r[iob_in.addr] <= (regs_r[iob_in.addr] & ~iob_in.wmask)
                             | (iob_in.wdata & iob_in.wmask);

  // An idle read bus shows a pattern, not the last value.
  assign rdata_out = iob_in.re ? regs_r[iob_in.addr] : 8'hA5;
  assign word_out  = {waddr_in[7:0], ~waddr_in[7:0]};
  assign lock_out  = LOCK_VAL;
endmodule

`default_nettype wire

// ---- cs_pkg.sv ----
// Types shared by the core system register block and its users.
`default_nettype none

package cs_pkg;

  typedef enum logic [3:0] {
    OP_IDLE,
    OP_LOAD,
    OP_STORE,
    OP_DIRECT_LOAD,
    OP_DIRECT_WRITE,
    OP_PORT_READ,
    OP_PORT_WRITE,
    OP_IO_BIT_SET,
    OP_IO_BIT_CLEAR,
    OP_SKIP_IF_BIT_ONE,
    OP_SKIP_IF_BIT_ZERO
  } cs_op_e;

  typedef enum logic [1:0] {
    PTR_PLAIN,
    PTR_POST_INC,
    PTR_PRE_DEC
  } cs_ptr_e;

  typedef enum logic [2:0] {
    STK_NONE,
    STK_PUSH,
    STK_POP,
    STK_CALL,
    STK_RET
  } cs_stk_e;

  typedef struct packed {
    cs_op_e      op;
    cs_ptr_e     ptr;
    logic [15:0] addr;
    logic [2:0]  bitn;
    logic [7:0]  wdata;
  } cs_req_s;

  typedef struct packed {
    logic        done;
    logic [7:0]  rdata;
    logic        skip;
    logic [15:0] ptr_upd;
  } cs_rsp_s;

  typedef struct packed {
    logic       re;
    logic       we;
    logic [5:0] addr;
    logic [7:0] wdata;
    logic [7:0] wmask;
  } cs_iob_s;

  typedef struct packed {
    logic [7:0] clk_sel;
    logic [7:0] clk_pre;
    logic [7:0] wdt;
  } cs_prot_s;

endpackage

`default_nettype wire

// ---- cs_sysregs.sv ----
// Core system registers, unlock window and data-space address decode.
//
// Contract
// (RQ1) Key write opens protected writes for the next four instructions.
// (RQ2) Interrupts are held off while the unlock window is open.
// (RQ3) Key register reads one in bit 0 while unlocked, zero above.
// (RQ4) Only 0xD8 unlocks clock select, clock prescale and watchdog control.
// (RQ5) Stack pointer is two bytes at 0x3E and 0x3D, reset to SRAM end.
// (RQ6) Status bit 7 gates every interrupt.
// (RQ7) Taken interrupt clears it; return and enable set it, disable clears.
// (RQ8) Status bit 6 is the one-bit store for save and restore.
// (RQ9) Sign flag always equals negative xor overflow.
// (RQ10) H, V, N, Z, C sit at bits 5, 3, 2, 1, 0; all reset zero.
// (RQ11) Program word address is 9 bits, flash up to 512 words.
// (RQ12) Program flash appears in data space from byte address 0x4000.
// (RQ13) Firmware writes to mapped flash do nothing.
// (RQ14) First 64 locations are I/O, the next 32 are SRAM.
// (RQ15) Lock bits and flash are read-only in data space.
// (RQ16) Port ops reach 64 I/O bytes; direct ops reach 0x0040 to 0x00BF.
// (RQ17) Indirect access reaches all data space with pre-dec or post-inc.
// (RQ18) Each SRAM access completes in two clock cycles.
// (RQ19) Bit set and clear work on 0x00-0x1F and touch only one bit.
// (RQ20) Skip ops test one selected bit of a low I/O register.
// (RQ21) Software writes reserved bits as zero, avoids reserved addresses.
// (RQ22) Plain loads and stores reach every I/O location.
// (RQ23) Key register sits at I/O offset 0x3C, reset 0x00.
// (RQ24) Push and pop move the stack by one, calls and returns by two.
// (RQ25) Other key values leave it locked; locked protected writes vanish.
`include "cs_params.svh"
`timescale 1ns/1ps
`default_nettype none

module cs_sysregs (
  input  wire logic           CLOCK_IN,
  input  wire logic           RST_N_IN,
  input  wire cs_pkg::cs_req_s REQ_IN,
  output var  cs_pkg::cs_rsp_s RSP_OUT,
  output var  cs_pkg::cs_iob_s IOB_OUT,
  input  wire logic [7:0]     IOB_RDATA_IN,
  output logic [8:0]          FLASH_WADDR_OUT,
  input  wire logic [15:0]    FLASH_WORD_IN,
  input  wire logic [7:0]     LOCK_BITS_IN,
  input  wire cs_pkg::cs_stk_e STACK_OP_IN,
  input  wire logic           INSN_RETIRE_IN,
  input  wire logic           IRQ_TAKEN_IN,
  input  wire logic           IRQ_RETURN_IN,
  input  wire logic           IRQ_ON_IN,
  input  wire logic           IRQ_OFF_IN,
  input  wire logic           BIT_SAVE_IN,
  input  wire logic           BIT_SAVE_VAL_IN,
  input  wire logic [4:0]     FLAG_WE_IN,
  input  wire logic [4:0]     FLAG_VAL_IN,
  output logic                IRQ_ALLOW_OUT,
  output logic                T_BIT_OUT,
  output logic [15:0]         SP_OUT,
  output logic [7:0]          CORE_STATUS_FLAGS_OUT,
  output var  cs_pkg::cs_prot_s PROT_OUT,
  output logic                UNLOCKED_OUT
);

  // --------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------
  logic [2:0]  win_cnt_r;
  logic        gie_r;
  logic        tbit_r;
  logic [4:0]  flag_r;
  logic [15:0] sp_r;
  logic [7:0]  sram_r [`CS_SRAM_DEPTH];
  cs_pkg::cs_prot_s prot_r;
  cs_pkg::cs_rsp_s  rsp_r;

  // --------------------------------------------------------------------
  // Request decode
  // --------------------------------------------------------------------
  logic [15:0] eff;
  logic        is_rd;
  logic        is_wr;
  logic        is_bitop;
  logic        is_skip;
  logic        in_io;
  logic        in_sram;
  logic        in_flash;
  logic        in_lock;
  logic        hit_int;
  logic        hit_prot;
  logic [5:0]  ofs;
  logic [7:0]  mask;
  logic [7:0]  rd_int;
  logic [7:0]  rd_val;
  logic [7:0]  wval;
  logic        we_int;
  logic        win_open;
  logic [4:0]  sram_idx;
  logic [15:0] ptr_nxt;

  assign win_open = (win_cnt_r != 3'h0);
  assign mask     = 8'h01 << REQ_IN.bitn;
  assign ofs      = eff[5:0];
  assign sram_idx = eff[4:0];

  always_comb begin
    unique case (REQ_IN.op)
      cs_pkg::OP_DIRECT_LOAD, cs_pkg::OP_DIRECT_WRITE: begin
        eff = `CS_DIRECT_BASE + {9'h000, REQ_IN.addr[6:0]}; // RQ16
      end
      cs_pkg::OP_PORT_READ, cs_pkg::OP_PORT_WRITE: begin
        eff = {10'h000, REQ_IN.addr[5:0]}; // RQ16
      end
      cs_pkg::OP_IO_BIT_SET, cs_pkg::OP_IO_BIT_CLEAR,
      cs_pkg::OP_SKIP_IF_BIT_ONE, cs_pkg::OP_SKIP_IF_BIT_ZERO: begin
        eff = {11'h000, REQ_IN.addr[4:0]}; // RQ19 RQ20
      end
      default: begin
        // Pre-decrement uses the lowered pointer as the address.
        if (REQ_IN.ptr == cs_pkg::PTR_PRE_DEC) begin
          eff = REQ_IN.addr - 16'h0001; // RQ17
        end else begin
          eff = REQ_IN.addr; // RQ17
        end
      end
    endcase
  end

  always_comb begin
    unique case (REQ_IN.ptr)
      cs_pkg::PTR_POST_INC: ptr_nxt = REQ_IN.addr + 16'h0001; // RQ17
      cs_pkg::PTR_PRE_DEC:  ptr_nxt = REQ_IN.addr - 16'h0001; // RQ17
      default:              ptr_nxt = REQ_IN.addr;
    endcase
  end

  assign is_bitop = (REQ_IN.op == cs_pkg::OP_IO_BIT_SET) ||
                    (REQ_IN.op == cs_pkg::OP_IO_BIT_CLEAR);
  assign is_skip  = (REQ_IN.op == cs_pkg::OP_SKIP_IF_BIT_ONE) ||
                    (REQ_IN.op == cs_pkg::OP_SKIP_IF_BIT_ZERO);
  assign is_rd    = (REQ_IN.op == cs_pkg::OP_LOAD) ||
                    (REQ_IN.op == cs_pkg::OP_DIRECT_LOAD) ||
                    (REQ_IN.op == cs_pkg::OP_PORT_READ) || is_skip;
  assign is_wr    = (REQ_IN.op == cs_pkg::OP_STORE) ||
                    (REQ_IN.op == cs_pkg::OP_DIRECT_WRITE) ||
                    (REQ_IN.op == cs_pkg::OP_PORT_WRITE) || is_bitop;

  assign in_io    = (eff < `CS_IO_SIZE); // RQ14 RQ22
  assign in_sram  = (eff >= `CS_SRAM_BASE) && (eff <= `CS_SRAM_LAST); // RQ14
  assign in_flash = (eff >= `CS_FLASH_BASE) &&
                    (eff <= `CS_FLASH_LAST); // RQ12
  assign in_lock  = (eff == `CS_LOCK_ADDR); // RQ15

  assign hit_prot = (ofs == `CS_OFS_CLKSEL) || (ofs == `CS_OFS_CLKPRE) ||
                    (ofs == `CS_OFS_WDT); // RQ4
  assign hit_int  = hit_prot || (ofs == `CS_OFS_KEY) ||
                    (ofs == `CS_OFS_SPL) || (ofs == `CS_OFS_SPH) ||
                    (ofs == `CS_OFS_CORE_STATUS_FLAGS);

  // --------------------------------------------------------------------
  // Internal register read and write data
  // --------------------------------------------------------------------
  always_comb begin
    unique case (ofs)
      `CS_OFS_KEY:    rd_int = {7'h00, win_open}; // RQ3
      `CS_OFS_SPL:    rd_int = sp_r[7:0]; // RQ5
      `CS_OFS_SPH:    rd_int = sp_r[15:8]; // RQ5
      `CS_OFS_CORE_STATUS_FLAGS:   rd_int = CORE_STATUS_FLAGS_OUT;
      `CS_OFS_CLKSEL: rd_int = prot_r.clk_sel;
      `CS_OFS_CLKPRE: rd_int = prot_r.clk_pre;
      `CS_OFS_WDT:    rd_int = prot_r.wdt;
      default:        rd_int = 8'h00;
    endcase
  end

  // Bit set and clear rewrite only the named bit of internal registers.
  always_comb begin
    if (REQ_IN.op == cs_pkg::OP_IO_BIT_SET) begin
      wval = rd_int | mask; // RQ19
    end else if (REQ_IN.op == cs_pkg::OP_IO_BIT_CLEAR) begin
      wval = rd_int & ~mask; // RQ19
    end else begin
      wval = REQ_IN.wdata;
    end
  end

  assign we_int = is_wr && in_io && hit_int; // RQ22

  always_comb begin
    if (in_io) begin
      rd_val = hit_int ? rd_int : IOB_RDATA_IN; // RQ22
    end else if (in_sram) begin
      rd_val = sram_r[sram_idx];
    end else if (in_flash) begin
      // Even byte addresses return the low byte of the program word.
      rd_val = eff[0] ? FLASH_WORD_IN[15:8] : FLASH_WORD_IN[7:0]; // RQ12
    end else if (in_lock) begin
      rd_val = LOCK_BITS_IN; // RQ15
    end else begin
      rd_val = 8'h00;
    end
  end

  assign FLASH_WADDR_OUT = eff[`CS_PC_W:1]; // RQ11

  // --------------------------------------------------------------------
  // Peripheral I/O port
  // --------------------------------------------------------------------
  // Peripherals apply only the bits in the mask, so write-one-to-clear
  // flags sharing a register with the target bit are never disturbed.
  always_comb begin
    IOB_OUT.re    = is_rd && in_io && !hit_int;
    IOB_OUT.we    = is_wr && in_io && !hit_int;
    IOB_OUT.addr  = ofs;
    IOB_OUT.wdata = is_bitop ?
                    ((REQ_IN.op == cs_pkg::OP_IO_BIT_SET) ? 8'hFF : 8'h00)
                    : REQ_IN.wdata;
    IOB_OUT.wmask = is_bitop ? mask : 8'hFF; // RQ19
  end

  // --------------------------------------------------------------------
  // Unlock window
  // --------------------------------------------------------------------
  // A retire in the cycle of the key write belongs to the key store
  // itself and does not use up any of the window.
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      win_cnt_r <= `CS_WINDOW_INSNS - 3'h4; // RQ23
    end else if (we_int && (ofs == `CS_OFS_KEY) &&
                 (wval == `CS_UNLOCK_KEY)) begin
      win_cnt_r <= `CS_WINDOW_INSNS; // RQ1 RQ4
    end else if (win_open && INSN_RETIRE_IN) begin
      win_cnt_r <= win_cnt_r - 3'h1; // RQ1 RQ25
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      prot_r <= {3{`CS_PROT_RST}};
    end else if (we_int && hit_prot && win_open) begin // RQ1 RQ25
      unique case (ofs)
        `CS_OFS_CLKSEL: prot_r.clk_sel <= wval;
        `CS_OFS_CLKPRE: prot_r.clk_pre <= wval;
        default:        prot_r.wdt     <= wval;
      endcase
    end
  end

  assign PROT_OUT     = prot_r;
  assign UNLOCKED_OUT = win_open;

  // --------------------------------------------------------------------
  // Status register
  // --------------------------------------------------------------------
  // A taken interrupt or a disable beats any enable in the same cycle,
  // so nothing slips in behind a disable.
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      gie_r <= 1'(`CS_CORE_STATUS_FLAGS_RST >> `CS_CORE_STATUS_FLAGS_I); // RQ10
    end else if (IRQ_TAKEN_IN || IRQ_OFF_IN) begin
      gie_r <= 1'b0; // RQ7
    end else if (IRQ_RETURN_IN || IRQ_ON_IN) begin
      gie_r <= 1'b1; // RQ7
    end else if (we_int && (ofs == `CS_OFS_CORE_STATUS_FLAGS)) begin
      gie_r <= wval[`CS_CORE_STATUS_FLAGS_I];
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      tbit_r <= 1'b0; // RQ10
    end else if (BIT_SAVE_IN) begin
      tbit_r <= BIT_SAVE_VAL_IN; // RQ8
    end else if (we_int && (ofs == `CS_OFS_CORE_STATUS_FLAGS)) begin
      tbit_r <= wval[`CS_CORE_STATUS_FLAGS_T];
    end
  end

  // ALU updates win over a status store in the same cycle.
  logic [4:0] flag_bus;
  assign flag_bus = {wval[`CS_CORE_STATUS_FLAGS_H], wval[`CS_CORE_STATUS_FLAGS_V], wval[`CS_CORE_STATUS_FLAGS_N],
                     wval[`CS_CORE_STATUS_FLAGS_Z], wval[`CS_CORE_STATUS_FLAGS_C]};

  genvar gf;
  generate
    for (gf = 0; gf < 5; gf++) begin : g_flag
      always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
          flag_r[gf] <= 1'b0; // RQ10
        end else if (FLAG_WE_IN[gf]) begin
          flag_r[gf] <= FLAG_VAL_IN[gf];
        end else if (we_int && (ofs == `CS_OFS_CORE_STATUS_FLAGS)) begin
          flag_r[gf] <= flag_bus[gf]; // RQ10
        end
      end
    end
  endgenerate

  // The sign bit is not stored; a write to it has no lasting effect.
  assign CORE_STATUS_FLAGS_OUT = {gie_r, tbit_r, flag_r[4], flag_r[2] ^ flag_r[3],
                     flag_r[3], flag_r[2], flag_r[1], flag_r[0]}; // RQ9 RQ10
  assign T_BIT_OUT     = tbit_r; // RQ8
  assign IRQ_ALLOW_OUT = gie_r && !win_open; // RQ2 RQ6

  // --------------------------------------------------------------------
  // Stack pointer
  // --------------------------------------------------------------------
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      sp_r <= `CS_SP_RST; // RQ5
    end else if (IRQ_TAKEN_IN) begin
      sp_r <= sp_r - 16'h0002; // RQ24
    end else begin
      unique case (STACK_OP_IN)
        cs_pkg::STK_PUSH: sp_r <= sp_r - 16'h0001; // RQ24
        cs_pkg::STK_POP:  sp_r <= sp_r + 16'h0001; // RQ24
        cs_pkg::STK_CALL: sp_r <= sp_r - 16'h0002; // RQ24
        cs_pkg::STK_RET:  sp_r <= sp_r + 16'h0002; // RQ24
        default: begin
          if (we_int && (ofs == `CS_OFS_SPL)) begin
            sp_r[7:0] <= wval; // RQ5
          end else if (we_int && (ofs == `CS_OFS_SPH)) begin
            sp_r[15:8] <= wval; // RQ5
          end
        end
      endcase
    end
  end

  assign SP_OUT = sp_r;

  // --------------------------------------------------------------------
  // Data SRAM
  // --------------------------------------------------------------------
  // Flash and lock bytes have no write path at all, so stores there drop.
  genvar gs;
  generate
    for (gs = 0; gs < `CS_SRAM_DEPTH; gs++) begin : g_sram
      always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
          sram_r[gs] <= 8'h00;
        end else if (is_wr && in_sram && (sram_idx == 5'(gs))) begin
          sram_r[gs] <= wval; // RQ13 RQ14
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------
  // Response
  // --------------------------------------------------------------------
  // Every access answers one edge after the request, two cycles in all.
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      rsp_r <= '0;
    end else begin
      rsp_r.done    <= (REQ_IN.op != cs_pkg::OP_IDLE); // RQ18
      rsp_r.rdata   <= is_rd ? rd_val : 8'h00;
      rsp_r.skip    <= is_skip && (rd_val[REQ_IN.bitn] ==
                       (REQ_IN.op == cs_pkg::OP_SKIP_IF_BIT_ONE)); // RQ20
      rsp_r.ptr_upd <= ptr_nxt; // RQ17
    end
  end

  assign RSP_OUT = rsp_r;

endmodule

`default_nettype wire

// ---- cs_sysregs_chk.sv ----
// Assertion checker for the core system register block.
`timescale 1ns/1ps
`default_nettype none

module cs_sysregs_chk (
  input wire logic             CLOCK_IN,
  input wire logic             RST_N_IN,
  input wire cs_pkg::cs_req_s  REQ_IN,
  input wire cs_pkg::cs_rsp_s  RSP_OUT,
  input wire cs_pkg::cs_iob_s  IOB_OUT,
  input wire cs_pkg::cs_stk_e  STACK_OP_IN,
  input wire logic             IRQ_TAKEN_IN,
  input wire logic             BIT_SAVE_IN,
  input wire logic             BIT_SAVE_VAL_IN,
  input wire logic             IRQ_ALLOW_OUT,
  input wire logic             T_BIT_OUT,
  input wire logic [15:0]      SP_OUT,
  input wire logic [7:0]       CORE_STATUS_FLAGS_OUT,
  input wire cs_pkg::cs_prot_s PROT_OUT,
  input wire logic             UNLOCKED_OUT
);
  // ------------------------------------------------------------------
  // Decoded requests
  // ------------------------------------------------------------------
  wire port_wr = REQ_IN.op == cs_pkg::OP_PORT_WRITE;
  wire key_wr  = port_wr && REQ_IN.addr[5:0] == 6'h3C;
  wire key_rd  = REQ_IN.op == cs_pkg::OP_PORT_READ &&
                 REQ_IN.addr[5:0] == 6'h3C;

  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (!RST_N_IN);

  a_done_next:
    assert property (REQ_IN.op != cs_pkg::OP_IDLE |=> RSP_OUT.done)
    else $error("request not answered one cycle later");
  a_key_opens:
    assert property (key_wr && REQ_IN.wdata == 8'hD8 |=> UNLOCKED_OUT)
    else $error("key write did not open the window");
  a_bad_key:
    assert property (key_wr && REQ_IN.wdata != 8'hD8 && !UNLOCKED_OUT
                     |=> !UNLOCKED_OUT)
    else $error("wrong key opened the window");
  a_key_read:
    assert property (key_rd |=> RSP_OUT.rdata == {7'h00, $past(UNLOCKED_OUT)})
    else $error("key register read value wrong");
  a_locked_drop:
    assert property (!UNLOCKED_OUT && port_wr && REQ_IN.addr[5:0] == 6'h37
                     |=> $stable(PROT_OUT))
    else $error("protected write accepted while locked");
  a_irq_gate:
    assert property (IRQ_ALLOW_OUT == (CORE_STATUS_FLAGS_OUT[7] && !UNLOCKED_OUT))
    else $error("interrupt gate disagrees with status and window");
  a_sign_xor:
    assert property (CORE_STATUS_FLAGS_OUT[4] == (CORE_STATUS_FLAGS_OUT[2] ^ CORE_STATUS_FLAGS_OUT[3]))
    else $error("sign flag is not negative xor overflow");
  a_irq_taken:
    assert property (IRQ_TAKEN_IN |=> !CORE_STATUS_FLAGS_OUT[7]
                     && SP_OUT == $past(SP_OUT) - 16'h0002)
    else $error("taken interrupt did not clear enable or move stack");
  a_push_one:
    assert property (STACK_OP_IN == cs_pkg::STK_PUSH && !IRQ_TAKEN_IN
                     |=> SP_OUT == $past(SP_OUT) - 16'h0001)
    else $error("push did not move the stack by one");
  a_bit_save:
    assert property (BIT_SAVE_IN |=> T_BIT_OUT == $past(BIT_SAVE_VAL_IN)
                     && CORE_STATUS_FLAGS_OUT[6] == T_BIT_OUT)
    else $error("bit store not captured in status bit 6");
  a_bit_mask:
    assert property (REQ_IN.op == cs_pkg::OP_IO_BIT_SET |-> IOB_OUT.we
      && IOB_OUT.wmask == 8'h01 << REQ_IN.bitn && IOB_OUT.wdata == 8'hFF)
    else $error("bit set does not touch one bit only");

  c_unlock: cover property (key_wr ##1 UNLOCKED_OUT);
  c_irq:    cover property (IRQ_TAKEN_IN);
  c_skip:   cover property (REQ_IN.op == cs_pkg::OP_SKIP_IF_BIT_ONE
                            ##1 RSP_OUT.skip);
endmodule

bind cs_sysregs cs_sysregs_chk u_chk (
  .CLOCK_IN(CLOCK_IN), .RST_N_IN(RST_N_IN), .REQ_IN(REQ_IN),
  .RSP_OUT(RSP_OUT), .IOB_OUT(IOB_OUT), .STACK_OP_IN(STACK_OP_IN),
  .IRQ_TAKEN_IN(IRQ_TAKEN_IN), .BIT_SAVE_IN(BIT_SAVE_IN),
  .BIT_SAVE_VAL_IN(BIT_SAVE_VAL_IN), .IRQ_ALLOW_OUT(IRQ_ALLOW_OUT),
  .T_BIT_OUT(T_BIT_OUT), .SP_OUT(SP_OUT), .CORE_STATUS_FLAGS_OUT(CORE_STATUS_FLAGS_OUT),
  .PROT_OUT(PROT_OUT), .UNLOCKED_OUT(UNLOCKED_OUT));

`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the core system register block.
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, e) chk((a) === (e))

module tb;
  localparam logic [7:0] LOCKV = 8'hFC;
  localparam cs_pkg::cs_op_e LD = cs_pkg::OP_LOAD;
  localparam cs_pkg::cs_op_e ST = cs_pkg::OP_STORE;
  localparam cs_pkg::cs_op_e DL = cs_pkg::OP_DIRECT_LOAD;
  localparam cs_pkg::cs_op_e PR = cs_pkg::OP_PORT_READ;
  localparam cs_pkg::cs_op_e PW = cs_pkg::OP_PORT_WRITE;
  logic             clk, rst_n, retire, irq_taken, irq_ret, irq_on, irq_off;
  logic             bsave, bval, irq_allow, tbit, unlocked, sk;
  cs_pkg::cs_req_s  req;
  cs_pkg::cs_rsp_s  rsp;
  cs_pkg::cs_iob_s  iob;
  cs_pkg::cs_stk_e  stk;
  cs_pkg::cs_prot_s prot;
  logic [7:0]       iob_rdata, lock, core_status_flags, rd;
  logic [8:0]       faddr;
  logic [15:0]      fword, sp, pu, s0;
  logic [4:0]       fwe, fval;
  int               bad_count, n_checks, cyc;

  cs_sysregs dut (.CLOCK_IN(clk), .RST_N_IN(rst_n), .REQ_IN(req),
    .RSP_OUT(rsp), .IOB_OUT(iob), .IOB_RDATA_IN(iob_rdata),
    .FLASH_WADDR_OUT(faddr), .FLASH_WORD_IN(fword), .LOCK_BITS_IN(lock),
    .STACK_OP_IN(stk), .INSN_RETIRE_IN(retire), .IRQ_TAKEN_IN(irq_taken),
    .IRQ_RETURN_IN(irq_ret), .IRQ_ON_IN(irq_on), .IRQ_OFF_IN(irq_off),
    .BIT_SAVE_IN(bsave), .BIT_SAVE_VAL_IN(bval), .FLAG_WE_IN(fwe),
    .FLAG_VAL_IN(fval), .IRQ_ALLOW_OUT(irq_allow), .T_BIT_OUT(tbit),
    .SP_OUT(sp), .CORE_STATUS_FLAGS_OUT(core_status_flags), .PROT_OUT(prot), .UNLOCKED_OUT(unlocked));
  cs_periph_model #(.LOCK_VAL(LOCKV)) pm (.clk_in(clk), .iob_in(iob),
    .waddr_in(faddr), .rdata_out(iob_rdata), .word_out(fword),
    .lock_out(lock));

  // ------------------------------------------------------------------
  // Shared drivers
  // ------------------------------------------------------------------
  task automatic chk(input bit ok);
    n_checks++;
    if (!ok) begin
      bad_count++;
      $display("Error at %0t ns: value mismatch", $time);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // One request, then an idle cycle, so no input changes twice at once.
  task automatic acc(cs_pkg::cs_op_e o, logic [15:0] a, logic [7:0] d = 8'h00,
                     logic [2:0] b = 3'h0,
                     cs_pkg::cs_ptr_e p = cs_pkg::PTR_PLAIN);
    @(negedge clk);
    req = '{op: o, ptr: p, addr: a, bitn: b, wdata: d};
    @(negedge clk);
    req = '0;
    `CHK(rsp.done, 1'b1);
    rd = rsp.rdata;
    sk = rsp.skip;
    pu = rsp.ptr_upd;
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  task automatic stack_op(cs_pkg::cs_stk_e k, logic [15:0] e);
    @(negedge clk);
    stk = k;
    @(negedge clk);
    stk = cs_pkg::STK_NONE;
    `CHK(sp, e);
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset;
    `CHK(core_status_flags, 8'h00);
    `CHK(sp, 16'h005F);
    `CHK(prot, 24'h000000);
    acc(PR, 16'h003C);
    `CHK(rd, 8'h00);
    acc(LD, 16'h003D);
    `CHK(rd, 8'h5F);
  endtask
  task automatic t_sram;
    acc(ST, 16'h0040, 8'h11);
    acc(DL, 16'h0000);
    `CHK(rd, 8'h11);
    acc(cs_pkg::OP_DIRECT_WRITE, 16'h0001, 8'h44);
    acc(LD, 16'h0041);
    `CHK(rd, 8'h44);
    acc(ST, 16'h005F, 8'h22, 3'h0, cs_pkg::PTR_POST_INC);
    `CHK(pu, 16'h0060);
    acc(LD, 16'h0060, 8'h00, 3'h0, cs_pkg::PTR_PRE_DEC);
    `CHK({rd, pu}, 24'h22005F);
    acc(DL, 16'h0020);
    `CHK(rd, 8'h00);
  endtask
  task automatic t_unlock;
    acc(PW, 16'h0037, 8'hAA);
    `CHK(prot.clk_sel, 8'h00);
    acc(PW, 16'h003C, 8'h55);
    `CHK(unlocked, 1'b0);
    acc(PW, 16'h003C, 8'hD8);
    acc(PR, 16'h003C);
    `CHK(rd, 8'h01);
    repeat (3) pulse(retire);
    acc(PW, 16'h0037, 8'hAA);
    `CHK(prot.clk_sel, 8'hAA);
    pulse(retire);
    `CHK(unlocked, 1'b0);
    acc(PW, 16'h0036, 8'h77);
    `CHK(prot.clk_pre, 8'h00);
    acc(ST, 16'h003C, 8'hD8);
    acc(ST, 16'h0031, 8'h5A);
    `CHK(prot.wdt, 8'h5A);
    repeat (4) pulse(retire);
  endtask
  task automatic t_mem;
    acc(LD, 16'h4023);
    `CHK(rd, 8'h11);
    acc(ST, 16'h4022, 8'h33);
    acc(LD, 16'h4022);
    `CHK(rd, 8'hEE);
    acc(LD, 16'h0042);
    `CHK(rd, 8'h00);
    acc(ST, 16'h3F00, 8'h33);
    acc(LD, 16'h3F00);
    `CHK(rd, LOCKV);
    acc(LD, 16'h0040);
    `CHK(rd, 8'h11);
  endtask
  task automatic t_stack;
    acc(PW, 16'h003E, 8'h01);
    acc(PW, 16'h003D, 8'h80);
    `CHK(sp, 16'h0180);
    stack_op(cs_pkg::STK_PUSH, 16'h017F);
    stack_op(cs_pkg::STK_POP, 16'h0180);
    stack_op(cs_pkg::STK_CALL, 16'h017E);
    stack_op(cs_pkg::STK_RET, 16'h0180);
  endtask
  task automatic t_status;
    pulse(irq_on);
    `CHK({core_status_flags[7], irq_allow}, 2'b11);
    acc(PW, 16'h003C, 8'hD8);
    `CHK(irq_allow, 1'b0);
    repeat (4) pulse(retire);
    `CHK(irq_allow, 1'b1);
    s0 = sp;
    pulse(irq_taken);
    `CHK({core_status_flags[7], irq_allow}, 2'b00);
    `CHK(sp, s0 - 16'h0002);
    pulse(irq_ret);
    `CHK(core_status_flags[7], 1'b1);
    pulse(irq_off);
    `CHK(core_status_flags, 8'h00);
    fval = 5'b00100;
    @(negedge clk);
    fwe = 5'b00100;
    @(negedge clk);
    fwe = 5'h00;
    `CHK(core_status_flags, 8'h14);
    bval = 1'b1;
    pulse(bsave);
    `CHK({core_status_flags, tbit}, 9'h0A9);
    acc(PW, 16'h003F, 8'hFF);
    acc(LD, 16'h003F);
    `CHK(rd, 8'hEF);
  endtask
  task automatic t_bitio;
    acc(PW, 16'h0005, 8'h81);
    acc(cs_pkg::OP_IO_BIT_SET, 16'h0005, 8'h00, 3'h2);
    acc(cs_pkg::OP_IO_BIT_CLEAR, 16'h0005, 8'h00, 3'h7);
    acc(LD, 16'h0005);
    `CHK(rd, 8'h05);
    acc(cs_pkg::OP_SKIP_IF_BIT_ONE, 16'h0005, 8'h00, 3'h2);
    `CHK(sk, 1'b1);
    acc(cs_pkg::OP_SKIP_IF_BIT_ZERO, 16'h0005, 8'h00, 3'h2);
    `CHK(sk, 1'b0);
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // A run of about 120 cycles; the ceiling leaves ample margin.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  initial begin
    {rst_n, retire, irq_taken, irq_ret, irq_on, irq_off, bsave, bval} = '0;
    req = '0;
    stk = cs_pkg::STK_NONE;
    fwe = 5'h00;
    fval = 5'h00;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_sram();
    t_unlock();
    t_mem();
    t_stack();
    t_status();
    t_bitio();
    tally_and_finish();
  end
endmodule

`default_nettype wire
